// file: core/ocal_telemetry.sv
// Output current telemetry with per-channel, per-phase gain and offset trims.
// Assumes sense words already digitised on i_clk, LSB 1/64 mV, and an SCL-clocked host.
`timescale 1ns/1ps
`default_nettype none
module ocal_telemetry #(
  parameter int N_PH = 6,
  parameter logic [6:0] DEV_ADDR = 7'h40
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_scl_clk,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic [2*N_PH-1:0][ocal_pkg::SNS_W-1:0] i_phase_sense_positive,
  input wire logic [2*N_PH-1:0][ocal_pkg::SNS_W-1:0] i_phase_sense_negative,
  output logic o_host_alert_out,
  output logic o_host_alert_oe
);
  localparam int NT = N_PH + 1;
  localparam int PW = $clog2(NT);
  localparam int NW = 20;

  logic [2:0] scl_s_ff;
  logic [2:0] sda_s_ff;
  logic [2:0] scl_hi_ff;
  logic sda_lv_ff;
  logic [2:0] seen_s_ff;
  logic seen_lv_ff;
  logic [1:0] frst_ff;
  logic frame_rst_n_ff;
  logic boot_ff;
  logic [7:0] page_ff;
  logic [7:0] phase_ff;
  logic [10:0] gain_ff [2][NT];
  logic [10:0] offs_ff [2][NT];
  logic [10:0] nvm_gain_ff [2][NT];
  logic [10:0] nvm_offs_ff [2][NT];
  logic [7:0] cml_ff;
  logic [15:0] rd_ff;
  logic alert_ff;
  logic sda_out_ff;
  ocal_pkg::ocal_link_s info;
  logic start_ev;
  logic stop_ev;
  logic seen_ev;
  logic wr_go;
  logic do_page;
  logic do_phase;
  logic do_gain;
  logic do_offs;
  logic do_store;
  logic do_restore;
  logic do_clear;
  logic bad_data;
  logic bad_cmd;
  logic gain_ok;
  logic offs_ok;
  logic sel_ok;
  logic tot_sel;
  logic rc;
  logic [PW-1:0] rp;
  logic signed [12:0] dif [2*N_PH];
  logic signed [NW-1:0] num;
  logic signed [NW-1:0] quo;
  logic signed [NW-1:0] cur;
  logic [10:0] cur_man;
  logic [10:0] rd_gain;
  logic [10:0] rd_offs;
  logic [15:0] rd_mux;
  logic [7:0] cml_set;

  // Link engine on the host clock
  ocal_link #(
    .DEV_ADDR(DEV_ADDR)
  ) u_link (
    .i_scl_clk(i_scl_clk),
    .i_arst_n(i_arst_n),
    .i_frame_rst_n(frame_rst_n_ff),
    .i_sda(i_sda),
    .i_rd_word(rd_ff),
    .o_info(info),
    .o_sda_oe(o_sda_oe)
  );

  // Pin and link levels through three stages, level taken when the last two agree
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_s_ff <= 3'h7;
      sda_s_ff <= 3'h7;
      seen_s_ff <= 3'h0;
      scl_hi_ff <= 3'h0;
      sda_lv_ff <= 1'b1;
      seen_lv_ff <= 1'b0;
    end else begin
      scl_s_ff <= {scl_s_ff[1:0], i_scl_clk};
      sda_s_ff <= {sda_s_ff[1:0], i_sda};
      seen_s_ff <= {seen_s_ff[1:0], info.seen};
      // Clock high time in cycles; bit-rate highs alias to short runs and never reach the limit
      scl_hi_ff <= (scl_s_ff[2] && scl_s_ff[1]) ? scl_hi_ff + 3'(scl_hi_ff != 3'h7) : 3'h0;
      if (sda_s_ff[2] == sda_s_ff[1]) begin
        sda_lv_ff <= sda_s_ff[2];
      end
      if (seen_s_ff[2] == seen_s_ff[1]) begin
        seen_lv_ff <= seen_s_ff[2];
      end
    end
  end

  // Start and stop are data edges after the clock has stood high for several cycles
  assign start_ev = scl_hi_ff >= 3'(ocal_pkg::SCL_HI_CYC) && sda_lv_ff && sda_s_ff[2] == sda_s_ff[1] && !sda_s_ff[2];
  assign stop_ev = scl_hi_ff >= 3'(ocal_pkg::SCL_HI_CYC) && !sda_lv_ff && sda_s_ff[2] == sda_s_ff[1] && sda_s_ff[2];
  assign seen_ev = !seen_lv_ff && seen_s_ff[2] == seen_s_ff[1] && seen_s_ff[2];
  assign wr_go = stop_ev && info.hit && !info.rw;

  // Start pulses the link framing into reset before the first clock rise
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      frst_ff <= 2'h0;
      frame_rst_n_ff <= 1'b0;
    end else begin
      if (start_ev) begin
        frst_ff <= 2'(ocal_pkg::FRAME_RST_CYC - 1);
      end else if (frst_ff != 2'h0) begin
        frst_ff <= frst_ff - 2'h1;
      end
      frame_rst_n_ff <= !(start_ev || frst_ff != 2'h0);
    end
  end

  // Accepted code sets
  always_comb begin
    gain_ok = info.data >= ocal_pkg::GAIN_MIN && info.data <= ocal_pkg::GAIN_MAX;
    if (phase_ff == ocal_pkg::SEL_TOTAL) begin
      offs_ok = !info.data[0] &&
        ((info.data >= ocal_pkg::OFFS_POS_MIN && info.data <= ocal_pkg::OFFS_TOT_POS_MAX) ||
         (info.data >= ocal_pkg::OFFS_TOT_NEG_MIN && info.data <= ocal_pkg::OFFS_NEG_MAX));
    end else begin
      offs_ok = (info.data >= ocal_pkg::OFFS_POS_MIN && info.data <= ocal_pkg::OFFS_PH_POS_MAX) ||
        (info.data >= ocal_pkg::OFFS_PH_NEG_MIN && info.data <= ocal_pkg::OFFS_NEG_MAX);
    end
    sel_ok = phase_ff < 8'(N_PH) || phase_ff == ocal_pkg::SEL_TOTAL || phase_ff == ocal_pkg::SEL_ALL;
  end

  // Write decode at the stop of an addressed write frame
  always_comb begin
    do_page = 1'b0;
    do_phase = 1'b0;
    do_gain = 1'b0;
    do_offs = 1'b0;
    do_store = 1'b0;
    do_restore = 1'b0;
    do_clear = 1'b0;
    bad_data = 1'b0;
    bad_cmd = 1'b0;
    if (wr_go) begin
      unique case (info.cmd)
        ocal_pkg::CMD_PAGE: begin
          if (info.wcnt == ocal_pkg::LEN_BYTE && (info.data[7:0] == ocal_pkg::PAGE_A ||
              info.data[7:0] == ocal_pkg::PAGE_B || info.data[7:0] == ocal_pkg::SEL_ALL)) begin
            do_page = 1'b1;
          end else if (info.wcnt != ocal_pkg::LEN_SEND) begin
            bad_data = 1'b1;
          end
        end
        ocal_pkg::CMD_PHASE: begin
          if (info.wcnt == ocal_pkg::LEN_BYTE && (info.data[7:0] < 8'(N_PH) ||
              info.data[7:0] == ocal_pkg::SEL_TOTAL || info.data[7:0] == ocal_pkg::SEL_ALL)) begin
            do_phase = 1'b1;
          end else if (info.wcnt != ocal_pkg::LEN_SEND) begin
            bad_data = 1'b1;
          end
        end
        ocal_pkg::CMD_GAIN: begin
          if (info.wcnt == ocal_pkg::LEN_WORD && gain_ok && sel_ok) begin
            do_gain = 1'b1;
          end else if (info.wcnt != ocal_pkg::LEN_SEND) begin
            bad_data = 1'b1;
          end
        end
        ocal_pkg::CMD_OFFS: begin
          if (info.wcnt == ocal_pkg::LEN_WORD && offs_ok && sel_ok) begin
            do_offs = 1'b1;
          end else if (info.wcnt != ocal_pkg::LEN_SEND) begin
            bad_data = 1'b1;
          end
        end
        ocal_pkg::CMD_STORE: do_store = info.wcnt == ocal_pkg::LEN_SEND;
        ocal_pkg::CMD_RESTORE: do_restore = info.wcnt == ocal_pkg::LEN_SEND;
        ocal_pkg::CMD_CLEAR: do_clear = info.wcnt == ocal_pkg::LEN_SEND;
        ocal_pkg::CMD_IOUT, ocal_pkg::CMD_SWORD, ocal_pkg::CMD_SCML: bad_data = info.wcnt > ocal_pkg::LEN_SEND;
        default: bad_cmd = info.wcnt > ocal_pkg::LEN_SEND;
      endcase
    end
  end

  // Channel and phase selectors
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      page_ff <= ocal_pkg::SEL_RST;
      phase_ff <= ocal_pkg::SEL_RST;
    end else begin
      if (do_page) begin
        page_ff <= info.data[7:0];
      end
      if (do_phase) begin
        phase_ff <= info.data[7:0];
      end
    end
  end

  // Restore from nonvolatile copy in the first cycle after reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      boot_ff <= 1'b1;
    end else begin
      boot_ff <= 1'b0;
    end
  end

  // Does entry (c, p) fall under the current page and phase
  function automatic logic hit_sel(input int c, input int p);
    logic ch;
    logic ph;
    ch = page_ff == ocal_pkg::SEL_ALL || page_ff == 8'(c);
    if (phase_ff == ocal_pkg::SEL_ALL) begin
      ph = p < N_PH;
    end else if (phase_ff == ocal_pkg::SEL_TOTAL) begin
      ph = p == N_PH;
    end else begin
      ph = phase_ff == 8'(p);
    end
    return ch && ph;
  endfunction

  // Live trims: bad words never land here
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int c = 0; c < 2; c++) begin
        for (int p = 0; p < NT; p++) begin
          gain_ff[c][p] <= ocal_pkg::GAIN_RST;
          offs_ff[c][p] <= ocal_pkg::OFFS_RST;
        end
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        for (int p = 0; p < NT; p++) begin
          if (boot_ff || do_restore) begin
            gain_ff[c][p] <= nvm_gain_ff[c][p];
            offs_ff[c][p] <= nvm_offs_ff[c][p];
          end else begin
            if (do_gain && hit_sel(c, p)) begin
              gain_ff[c][p] <= info.data[10:0];
            end
            if (do_offs && hit_sel(c, p)) begin
              offs_ff[c][p] <= info.data[10:0];
            end
          end
        end
      end
    end
  end

  // Nonvolatile copy, factory default is 5 milliohm and zero offset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int c = 0; c < 2; c++) begin
        for (int p = 0; p < NT; p++) begin
          nvm_gain_ff[c][p] <= ocal_pkg::GAIN_RST;
          nvm_offs_ff[c][p] <= ocal_pkg::OFFS_RST;
        end
      end
    end else if (do_store) begin
      for (int c = 0; c < 2; c++) begin
        for (int p = 0; p < NT; p++) begin
          nvm_gain_ff[c][p] <= gain_ff[c][p];
          nvm_offs_ff[c][p] <= offs_ff[c][p];
        end
      end
    end
  end

  // Per-phase sense difference
  for (genvar k = 0; k < 2 * N_PH; k++) begin : g_dif
    assign dif[k] = $signed({1'b0, i_phase_sense_positive[k]}) - $signed({1'b0, i_phase_sense_negative[k]});
  end

  // Read target: page B only when selected alone, total at 80h
  assign tot_sel = phase_ff == ocal_pkg::SEL_TOTAL;
  assign rc = page_ff == ocal_pkg::PAGE_B;
  assign rp = tot_sel ? PW'(N_PH) : (phase_ff == ocal_pkg::SEL_ALL ? PW'(0) : phase_ff[PW-1:0]);
  assign rd_gain = gain_ff[rc][rp];
  assign rd_offs = offs_ff[rc][rp];

  // Current in 0.125 A steps: eight times sense over gain, plus offset
  always_comb begin
    num = '0;
    if (tot_sel) begin
      for (int k = 0; k < N_PH; k++) begin
        num = num + NW'(dif[(rc ? N_PH : 0) + k]);
      end
    end else begin
      num = NW'(dif[(rc ? N_PH : 0) + int'(rp)]);
    end
    quo = (num <<< 3) / $signed({1'b0, rd_gain});
    cur = quo + NW'($signed(rd_offs));
    if (cur > NW'(1023)) begin
      cur_man = 11'h3ff;
    end else if (cur < -NW'(1024)) begin
      cur_man = 11'h400;
    end else begin
      cur_man = cur[10:0];
    end
  end

  // Word returned for the command just received
  always_comb begin
    unique case (info.cmd)
      ocal_pkg::CMD_PAGE: rd_mux = {8'h00, page_ff};
      ocal_pkg::CMD_PHASE: rd_mux = {8'h00, phase_ff};
      ocal_pkg::CMD_GAIN: rd_mux = {ocal_pkg::GAIN_EXP, rd_gain};
      ocal_pkg::CMD_OFFS: rd_mux = {ocal_pkg::OFFS_EXP, rd_offs};
      ocal_pkg::CMD_IOUT: rd_mux = {ocal_pkg::IOUT_EXP, cur_man};
      ocal_pkg::CMD_SWORD: rd_mux = 16'(|cml_ff) << ocal_pkg::SW_CML;
      ocal_pkg::CMD_SCML: rd_mux = {8'h00, cml_ff};
      default: rd_mux = 16'h0000;
    endcase
  end

  // Snapshot once the command byte has arrived, held through the read
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_ff <= 16'h0000;
    end else if (seen_ev) begin
      rd_ff <= rd_mux;
    end
  end

  // Communication faults, a new fault wins over a clear
  always_comb begin
    cml_set = 8'h00;
    cml_set[ocal_pkg::CML_BAD_DATA] = bad_data;
    cml_set[ocal_pkg::CML_BAD_CMD] = bad_cmd;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cml_ff <= ocal_pkg::CML_RST;
    end else begin
      cml_ff <= (do_clear ? 8'h00 : cml_ff) | cml_set;
    end
  end

  // Alert is open drain, pulled low while any fault stands
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      alert_ff <= 1'b0;
      sda_out_ff <= 1'b0;
    end else begin
      alert_ff <= (|cml_ff) && !do_clear || (|cml_set);
      sda_out_ff <= 1'b0;
    end
  end

  assign o_host_alert_oe = alert_ff;
  assign o_host_alert_out = sda_out_ff;
  assign o_sda_out = sda_out_ff;
endmodule // ocal_telemetry
`default_nettype wire

// file: core/ocal_pkg.sv
// Constants, field layouts and carriers for output current telemetry and trim.
// Assumes a 40 MHz system clock and a PMBus link clocked by its own SCL.
package ocal_pkg;
  localparam int SNS_W = 12;
  localparam int MAN_W = 11;
  localparam int FRAME_RST_CYC = 2;
  localparam int SCL_HI_CYC = 4;
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_PHASE = 8'h04;
  localparam logic [7:0] CMD_STORE = 8'h11;
  localparam logic [7:0] CMD_RESTORE = 8'h12;
  localparam logic [7:0] CMD_GAIN = 8'h38;
  localparam logic [7:0] CMD_OFFS = 8'h39;
  localparam logic [7:0] CMD_SWORD = 8'h79;
  localparam logic [7:0] CMD_SCML = 8'h7e;
  localparam logic [7:0] CMD_IOUT = 8'h8c;
  localparam logic [7:0] PAGE_A = 8'h00;
  localparam logic [7:0] PAGE_B = 8'h01;
  localparam logic [7:0] SEL_ALL = 8'hff;
  localparam logic [7:0] SEL_TOTAL = 8'h80;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [2:0] LEN_SEND = 3'h1;
  localparam logic [2:0] LEN_BYTE = 3'h2;
  localparam logic [2:0] LEN_WORD = 3'h3;
  localparam logic [4:0] GAIN_EXP = 5'h1a;
  localparam logic [4:0] OFFS_EXP = 5'h1d;
  localparam logic [4:0] IOUT_EXP = 5'h1d;
  localparam logic [15:0] GAIN_MIN = 16'hd131;
  localparam logic [15:0] GAIN_MAX = 16'hd150;
  localparam logic [10:0] GAIN_RST = 11'h140;
  localparam logic [10:0] OFFS_RST = 11'h000;
  localparam logic [15:0] OFFS_POS_MIN = 16'he800;
  localparam logic [15:0] OFFS_PH_POS_MAX = 16'he808;
  localparam logic [15:0] OFFS_PH_NEG_MIN = 16'heff9;
  localparam logic [15:0] OFFS_TOT_POS_MAX = 16'he820;
  localparam logic [15:0] OFFS_TOT_NEG_MIN = 16'hefe2;
  localparam logic [15:0] OFFS_NEG_MAX = 16'hefff;
  localparam int CML_BAD_CMD = 7;
  localparam int CML_BAD_DATA = 6;
  localparam int SW_CML = 1;
  localparam logic [7:0] CML_RST = 8'h00;

  // Linear format word: signed exponent over signed mantissa
  typedef struct packed {
    logic [4:0] exp;
    logic [10:0] man;
  } ocal_lin_s;

  // What the link engine collected in the current frame
  typedef struct packed {
    logic hit;
    logic rw;
    logic seen;
    logic [2:0] wcnt;
    logic [7:0] cmd;
    logic [15:0] data;
  } ocal_link_s;
endpackage

// file: core/ocal_link.sv
// PMBus byte engine on the link clock: address match, write capture, read shift.
// Assumes a frame reset pulse from the system side at each start condition.
`timescale 1ns/1ps
`default_nettype none
module ocal_link #(
  parameter logic [6:0] DEV_ADDR = 7'h40
) (
  input wire logic i_scl_clk,
  input wire logic i_arst_n,
  input wire logic i_frame_rst_n,
  input wire logic i_sda,
  input wire logic [15:0] i_rd_word,
  output var ocal_pkg::ocal_link_s o_info,
  output logic o_sda_oe
);
  logic [3:0] bit_ff;
  logic [7:0] sh_ff;
  logic [2:0] byte_ff;
  logic hit_ff;
  logic rw_ff;
  logic rbyte_ff;
  logic [2:0] wcnt_ff;
  logic seen_ff;
  logic [7:0] cmd_ff;
  logic [15:0] data_ff;
  logic oe_ff;
  logic [7:0] rx;
  logic [7:0] tx;

  assign rx = {sh_ff[6:0], i_sda};
  // Read word is held still by the system side while bytes shift out
  assign tx = rbyte_ff ? i_rd_word[15:8] : i_rd_word[7:0];

  // Bit and byte framing, cleared at every start
  always_ff @(posedge i_scl_clk or negedge i_frame_rst_n) begin
    if (!i_frame_rst_n) begin
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      byte_ff <= 3'h0;
      hit_ff <= 1'b0;
      rw_ff <= 1'b0;
      rbyte_ff <= 1'b0;
      wcnt_ff <= 3'h0;
      seen_ff <= 1'b0;
    end else if (bit_ff == 4'h8) begin
      bit_ff <= 4'h0;
      if (byte_ff != 3'h7) begin
        byte_ff <= byte_ff + 3'h1;
      end
      if (rw_ff && byte_ff != 3'h0) begin
        rbyte_ff <= 1'b1;
      end
    end else begin
      bit_ff <= bit_ff + 4'h1;
      sh_ff <= rx;
      if (bit_ff == 4'h7) begin
        if (byte_ff == 3'h0) begin
          hit_ff <= (rx[7:1] == DEV_ADDR);
          rw_ff <= rx[0];
        end else if (hit_ff && !rw_ff && wcnt_ff != 3'h7) begin
          wcnt_ff <= wcnt_ff + 3'h1;
          seen_ff <= 1'b1;
        end
      end
    end
  end

  // Command and data bytes survive a repeated start
  always_ff @(posedge i_scl_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmd_ff <= 8'h00;
      data_ff <= 16'h0000;
    end else if (bit_ff == 4'h7 && byte_ff != 3'h0 && hit_ff && !rw_ff) begin
      unique case (wcnt_ff)
        3'h0: cmd_ff <= rx;
        3'h1: data_ff[7:0] <= rx;
        3'h2: data_ff[15:8] <= rx;
        default: ;
      endcase
    end
  end

  // Acknowledge and read data change on the falling edge
  always_ff @(negedge i_scl_clk or negedge i_frame_rst_n) begin
    if (!i_frame_rst_n) begin
      oe_ff <= 1'b0;
    end else if (bit_ff == 4'h8) begin
      oe_ff <= (byte_ff == 3'h0) ? hit_ff : (hit_ff && !rw_ff);
    end else begin
      oe_ff <= hit_ff && rw_ff && byte_ff != 3'h0 && byte_ff < 3'h3 && !tx[~bit_ff[2:0]];
    end
  end

  assign o_info = '{hit: hit_ff, rw: rw_ff, seen: seen_ff, wcnt: wcnt_ff, cmd: cmd_ff, data: data_ff};
  assign o_sda_oe = oe_ff;
endmodule // ocal_link
`default_nettype wire

// file: sim/ocal_telemetry_checker.sv
// Port checker for the current trim block: open-drain levels, alert timing, framing.
// Assumes it is bound to the top module; every check runs on the system clock.
`timescale 1ns/1ps
`default_nettype none
module ocal_telemetry_checker (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_scl_clk,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_host_alert_out,
  input wire logic o_host_alert_oe
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  // Both lines released and high
  sequence bus_idle;
    (i_scl_clk && i_sda)[*2];
  endsequence

  // Host start: data falls while the clock rests high
  sequence host_start;
    i_scl_clk[*6] ##0 $fell(i_sda);
  endsequence

  // Open-drain outputs only ever drive low
  chk_sda_drive_low: assert property (o_sda_out == 1'b0)
    else $error("data pin value not low");
  chk_alert_drive_low: assert property (o_host_alert_out == 1'b0)
    else $error("alert pin value not low");
  // Faults are flagged only once a frame has ended
  chk_alert_rise_idle: assert property ($rose(o_host_alert_oe) |-> bus_idle)
    else $error("alert rose outside bus idle");
  chk_alert_fall_idle: assert property ($fell(o_host_alert_oe) |-> bus_idle)
    else $error("alert fell outside bus idle");
  chk_alert_held_on: assert property ($rose(o_host_alert_oe) |=> o_host_alert_oe[*8])
    else $error("alert did not hold");
  chk_alert_frame_stable: assert property (!i_scl_clk |-> $stable(o_host_alert_oe))
    else $error("alert moved inside a frame");
  // Device never holds data low across a host start
  chk_start_released: assert property (host_start |-> !o_sda_oe)
    else $error("data pulled at start");
  chk_reset_quiet: assert property ($rose(i_arst_n) |-> !o_host_alert_oe && !o_sda_oe)
    else $error("outputs active after reset");
endmodule // ocal_telemetry_checker

bind ocal_telemetry ocal_telemetry_checker ocal_telemetry_checker_inst (
  .i_clk(i_clk),
  .i_arst_n(i_arst_n),
  .i_scl_clk(i_scl_clk),
  .i_sda(i_sda),
  .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe),
  .o_host_alert_out(o_host_alert_out),
  .o_host_alert_oe(o_host_alert_oe)
);
`default_nettype wire

// file: sim/ocal_host.sv
// Host model: bit-banged bus frames, clock only toggles inside frames.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module ocal_host #(
  parameter logic [6:0] DEV_ADDR = 7'h40
) (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  int nak;
  // Idle: clock high, data released
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
    nak = 0;
  end
  // One bit at a 30 ns clock period, data changed while clock low
  task automatic bit_io(input logic b, output logic s);
    o_sda_oe = !b;
    #7 o_scl = 1'b1;
    #8 s = i_sda;
    #7 o_scl = 1'b0;
    #8;
  endtask
  // Byte plus acknowledge bit; missing device acks are counted
  task automatic xfer(input logic [7:0] d, input logic ab, input logic chk, output logic [7:0] q);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ab, s);
    if (chk && s) nak++;
  endtask
  // Start or repeated start, long clock high before it
  task automatic start();
    o_sda_oe = 1'b0;
    #200 o_scl = 1'b1;
    #200 o_sda_oe = 1'b1;
    #200 o_scl = 1'b0;
    #8;
  endtask
  task automatic stop();
    o_sda_oe = 1'b1;
    #200 o_scl = 1'b1;
    #200 o_sda_oe = 1'b0;
    #600;
  endtask
  // Write frame: len 1 send, 2 byte, 3 word low byte first
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int len);
    logic [7:0] q;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, 1'b1, q);
    xfer(cmd, 1'b1, 1'b1, q);
    if (len > 1) xfer(d[7:0], 1'b1, 1'b1, q);
    if (len > 2) xfer(d[15:8], 1'b1, 1'b1, q);
    stop();
  endtask
  // Word read through a repeated start, last byte not acked
  task automatic rd(input logic [7:0] cmd, output logic [15:0] d);
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, 1'b1, d[7:0]);
    xfer(cmd, 1'b1, 1'b1, d[7:0]);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, 1'b1, d[7:0]);
    xfer(8'hff, 1'b0, 1'b0, d[7:0]);
    xfer(8'hff, 1'b1, 1'b0, d[15:8]);
    stop();
  endtask
endmodule // ocal_host
`default_nettype wire

// file: sim/ocal_telemetry_tb_top.sv
// Bench: host model writes trims and reads telemetry, results compared here.
// Assumes the package, design, checker and host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ocal_telemetry_tb_top;
  localparam int NP = 6;
  typedef struct packed {
    logic [7:0] pg;
    logic [7:0] ph;
    logic [7:0] cmd;
    logic [15:0] val;
    logic [1:0] len;
    logic [15:0] back;
    logic bad;
  } ocal_wr_s;
  logic clk, arst_n, scl, sda, h_oe, d_oe, alert_oe;
  logic [2*NP-1:0][11:0] pos, neg;
  int err_count, cmp_count, seed = 45, cyc = 0, p;
  logic [15:0] g;
  // Write steps: selection, command, data, length, read-back, refused
  ocal_wr_s wt [14] = '{
    '{8'h01, 8'h03, 8'h38, 16'hd131, 2'h3, 16'hd131, 1'b0}, '{8'h01, 8'h03, 8'h38, 16'hd150, 2'h3, 16'hd150, 1'b0},
    '{8'h01, 8'h03, 8'h38, 16'hd151, 2'h3, 16'hd150, 1'b1}, '{8'h01, 8'h03, 8'h38, 16'hd130, 2'h3, 16'hd150, 1'b1},
    '{8'h01, 8'h03, 8'h38, 16'h1140, 2'h3, 16'hd150, 1'b1}, '{8'h01, 8'h03, 8'h38, 16'hd131, 2'h2, 16'hd150, 1'b1},
    '{8'h00, 8'h02, 8'h39, 16'he808, 2'h3, 16'he808, 1'b0}, '{8'h00, 8'h02, 8'h39, 16'heff8, 2'h3, 16'he808, 1'b1},
    '{8'h00, 8'h80, 8'h39, 16'he820, 2'h3, 16'he820, 1'b0}, '{8'h00, 8'h80, 8'h39, 16'he801, 2'h3, 16'he820, 1'b1},
    '{8'h00, 8'h80, 8'h39, 16'hefe2, 2'h3, 16'hefe2, 1'b0}, '{8'h00, 8'h80, 8'h38, 16'hd13d, 2'h3, 16'hd13d, 1'b0},
    '{8'h02, 8'h00, 8'h38, 16'hd148, 2'h3, 16'hd148, 1'b1}, '{8'h00, 8'h06, 8'h38, 16'hd13f, 2'h3, 16'hd13f, 1'b1}};
  // Telemetry points (gain in val, offset in back) and trims after restore
  ocal_wr_s it [4] = '{'{8'h00, 8'h00, 8'h8c, 16'hd13f, 2'h0, 16'he800, 1'b0},
    '{8'h00, 8'h02, 8'h8c, 16'hd140, 2'h0, 16'he808, 1'b0}, '{8'h01, 8'h03, 8'h8c, 16'hd150, 2'h0, 16'he800, 1'b0},
    '{8'h00, 8'h80, 8'h8c, 16'hd13d, 2'h0, 16'hefe2, 1'b0}};
  ocal_wr_s rt [4] = '{'{8'h01, 8'h05, 8'h38, 16'h0000, 2'h0, 16'hd135, 1'b0},
    '{8'h00, 8'h01, 8'h38, 16'h0000, 2'h0, 16'hd135, 1'b0}, '{8'h00, 8'h80, 8'h38, 16'h0000, 2'h0, 16'hd13d, 1'b0},
    '{8'h00, 8'h02, 8'h39, 16'h0000, 2'h0, 16'he808, 1'b0}};

  // Open-drain data wire with pull-up
  assign sda = !(h_oe || d_oe);

  ocal_telemetry #(.N_PH(NP), .DEV_ADDR(7'h40)) ocal_telemetry_inst (
    .i_clk(clk), .i_arst_n(arst_n), .i_scl_clk(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(d_oe),
    .i_phase_sense_positive(pos), .i_phase_sense_negative(neg), .o_host_alert_out(), .o_host_alert_oe(alert_oe));
  ocal_host #(.DEV_ADDR(7'h40)) ocal_host_inst (.i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end

  // Summed sense of one phase, or of the whole channel for the total selector
  function automatic int diff(input logic ch, input logic [7:0] ph);
    int s;
    s = 0;
    for (int k = 0; k < NP; k++) begin
      if (ph == 8'h80 || ph == 8'(k)) s += int'(pos[int'(ch)*NP+k]) - int'(neg[int'(ch)*NP+k]);
    end
    return s;
  endfunction
  // Reported current: eight times sense over gain plus offset, saturated mantissa
  function automatic logic [15:0] exp_iout(input int d, input logic [15:0] gn, input logic [15:0] o);
    int m;
    m = 8 * d / int'(gn[10:0]) + int'($signed(o[10:0]));
    if (m > 1023) m = 1023;
    if (m < -1024) m = -1024;
    return {5'h1d, m[10:0]};
  endfunction

  task automatic cmp_w(input string nm, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cmp_b(input string nm, input logic e, input logic s);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %b seen %b", nm, e, s);
    end
  endtask
  task automatic sel(input logic [7:0] pg, input logic [7:0] ph);
    ocal_host_inst.wr(8'h00, {8'h00, pg}, 2);
    ocal_host_inst.wr(8'h04, {8'h00, ph}, 2);
  endtask
  task automatic rd_cmp(input string nm, input logic [7:0] cmd, input logic [15:0] e);
    logic [15:0] q;
    ocal_host_inst.rd(cmd, q);
    cmp_w(nm, e, q);
  endtask
  task automatic complete_run();
    $display("Compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      $display("Error timeout expected done seen running");
      complete_run();
    end
  end

  initial begin
    err_count = 0;
    cmp_count = 0;
    arst_n = 1'b0;
    // Sense pairs held for the run, positive in the upper half of the sense range, negative below 256
    for (int i = 0; i < 2*NP; i++) begin
      pos[i] = {1'b1, 11'($random(seed))};
      neg[i] = {4'h0, 8'($random(seed))};
    end
    repeat (16) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    repeat (8) @(negedge clk);
    rd_cmp("gain reset", 8'h38, 16'hd140);
    rd_cmp("offset reset", 8'h39, 16'he800);
    $display("reset values done");
    foreach (wt[i]) begin
      sel(wt[i].pg, wt[i].ph);
      ocal_host_inst.wr(wt[i].cmd, wt[i].val, int'(wt[i].len));
      cmp_b("alert", wt[i].bad, alert_oe);
      rd_cmp("status", 8'h7e, {9'h000, wt[i].bad, 6'h00});
      rd_cmp("status word", 8'h79, {14'h0000, wt[i].bad, 1'b0});
      rd_cmp("trim", wt[i].cmd, wt[i].back);
      ocal_host_inst.wr(8'h03, 16'h0000, 1);
      cmp_b("alert clear", 1'b0, alert_oe);
    end
    // Unknown command carrying data flags bit 7 and raises the alert
    ocal_host_inst.wr(8'h20, 16'h0055, 2);
    cmp_b("alert unknown", 1'b1, alert_oe);
    rd_cmp("status unknown", 8'h7e, 16'h0080);
    ocal_host_inst.wr(8'h03, 16'h0000, 1);
    $display("trim writes done");
    foreach (it[i]) begin
      sel(it[i].pg, it[i].ph);
      rd_cmp("iout", 8'h8c, exp_iout(diff(it[i].pg[0], it[i].ph), it[i].val, it[i].back));
    end
    $display("telemetry done");
    sel(8'hff, 8'hff);
    ocal_host_inst.wr(8'h38, 16'hd135, 3);
    ocal_host_inst.wr(8'h11, 16'h0000, 1);
    ocal_host_inst.wr(8'h38, 16'hd150, 3);
    ocal_host_inst.wr(8'h12, 16'h0000, 1);
    foreach (rt[i]) begin
      sel(rt[i].pg, rt[i].ph);
      rd_cmp("stored trim", rt[i].cmd, rt[i].back);
    end
    $display("store and broadcast done");
    for (int i = 0; i < 4; i++) begin
      p = int'($unsigned($random(seed)) % NP);
      g = 16'hd131 + 16'($unsigned($random(seed)) % 32);
      sel(8'h01, 8'(p));
      ocal_host_inst.wr(8'h38, g, 3);
      rd_cmp("random iout", 8'h8c, exp_iout(diff(1'b1, 8'(p)), g, 16'he800));
    end
    cmp_w("missing acks", 16'h0000, 16'(ocal_host_inst.nak));
    $display("random gains done");
    complete_run();
  end
endmodule // ocal_telemetry_tb_top
`default_nettype wire
